/* File: design/irq_prio_cfg.svh */
/*
  Register offsets, field positions, write masks and reset values for the
  interrupt priority register slice. Included by the package and the design.
*/
`ifndef IRQ_PRIO_CFG_SVH
`define IRQ_PRIO_CFG_SVH

`define PRIO_OFS_CAN_SPI 12'h000
`define PRIO_OFS_CAPTURE_DMA 12'h004
`define PRIO_OFS_TWOWIRE2 12'h008
`define PRIO_OFS_EXT_PINS 12'h00C
`define PRIO_OFS_ENCODER_PWM 12'h010
`define PRIO_OFS_SERIAL_ERRORS 12'h014
`define PRIO_OFS_CAN_TRANSMIT 12'h018
`define PRIO_OFS_FEATURES 12'h01C

`define PRIO_FIELD_HI 14
`define PRIO_FIELD_B 10
`define PRIO_FIELD_C 6
`define PRIO_FIELD_D 2
`define PRIO_FIELD_W 3

`define PRIO_FIELD_RESET 3'h4
`define PRIO_LEVEL_MAX 3'h7
`define PRIO_LEVEL_MIN 3'h1
`define PRIO_LEVEL_OFF 3'h0

`define PRIO_MASK_CAN_SPI 16'h7777
`define PRIO_MASK_CAPTURE_DMA 16'h0777
`define PRIO_MASK_MID_PAIR 16'h0770
`define PRIO_MASK_CAN_TRANSMIT 16'h0700

`define PRIO_RESET_CAN_SPI 16'h4444
`define PRIO_RESET_CAPTURE_DMA 16'h0444
`define PRIO_RESET_MID_PAIR 16'h0440
`define PRIO_RESET_CAN_TRANSMIT 16'h0400

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: design/irq_prio_pkg.sv */
/*
  Types shared by the priority register slice.
  Assumes the configuration header is on the include path.
*/
`include "irq_prio_cfg.svh"

package irq_prio_pkg;

  typedef logic [2:0] prio_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rd_state_t;

endpackage : irq_prio_pkg

/* File: design/irq_priority_regs_part.sv */
/*
  Seven interrupt priority registers reached over an AXI4-Lite slave, with
  each source's effective priority driven out to the arbitration logic.
  Assumes a single 125 MHz clock, a synchronous active-low reset, and an
  AXI4-Lite master that keeps at most one write and one read outstanding.
*/
// Notes on behaviour
// - Each source has a 3-bit priority; value 7 is the highest level.
// - Value 1 is the lowest enabled level; 2 to 6 rise in order.
// - Value 0 disables the source entirely.
// - Unimplemented bits ignore writes and read back as zero.
// - Every field resets to 4 and is readable and writable.
// - CAN event at bits 14:12, CAN receive ready at 10:8.
// - Without a CAN controller the CAN sources stay disabled.
// - Second serial port event at 6:4, its error at 2:0.
// - Capture 4 at 10:8, capture 3 at 6:4, bits 15:11 unused.
// - Transfer channel 3 complete priority at bits 2:0 of that register.
// - Second two-wire master at 10:8, slave at 6:4, 3:0 unused.
// - External pin 4 at 10:8, pin 3 at 6:4, rest unused.
// - Encoder at 10:8, PWM special event match at 6:4.
// - UART B error at 10:8, UART A error at 6:4, 3:0 unused.
// - CAN transmit request at 10:8, all else unused.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_cfg.svh"

module irq_priority_regs_part (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic can_present,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] can_event_prio,
  output logic [2:0] can_rx_ready_prio,
  output logic [2:0] serial_port_b_event_prio,
  output logic [2:0] serial_port_b_error_prio,
  output logic [2:0] capture_four_prio,
  output logic [2:0] capture_three_prio,
  output logic [2:0] xfer_chan_three_prio,
  output logic [2:0] twowire_b_master_prio,
  output logic [2:0] twowire_b_slave_prio,
  output logic [2:0] ext_pin_four_prio,
  output logic [2:0] ext_pin_three_prio,
  output logic [2:0] encoder_prio,
  output logic [2:0] pwm_special_match_prio,
  output logic [2:0] uart_b_error_prio,
  output logic [2:0] uart_a_error_prio,
  output logic [2:0] can_tx_request_prio
);

  // Register storage; index order follows the offset constants.
  logic [15:0] prio_ctrl_can_spi_q, prio_ctrl_can_spi_d;
  logic [15:0] prio_ctrl_capture_dma_q, prio_ctrl_capture_dma_d;
  logic [15:0] prio_ctrl_twowire2_q, prio_ctrl_twowire2_d;
  logic [15:0] prio_ctrl_ext_pins_q, prio_ctrl_ext_pins_d;
  logic [15:0] prio_ctrl_encoder_pwm_q, prio_ctrl_encoder_pwm_d;
  logic [15:0] prio_ctrl_serial_errors_q, prio_ctrl_serial_errors_d;
  logic [15:0] prio_ctrl_can_transmit_q, prio_ctrl_can_transmit_d;
  logic can_present_q, can_present_d;
  // Readies and gated CAN levels are flops so that no output has logic after it.
  logic aw_ready_q, aw_ready_d;
  logic w_ready_q, w_ready_d;
  logic [2:0] can_event_prio_q, can_event_prio_d;
  logic [2:0] can_rx_ready_prio_q, can_rx_ready_prio_d;
  logic [2:0] can_tx_request_prio_q, can_tx_request_prio_d;

  irq_prio_pkg::wr_state_t wr_state_q, wr_state_d;
  irq_prio_pkg::rd_state_t rd_state_q, rd_state_d;
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  logic aw_fire, w_fire, wr_go, rd_go;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;

  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  assign wr_go = (wr_state_q == irq_prio_pkg::WR_IDLE) && (aw_held_q || aw_fire)
                 && (w_held_q || w_fire);
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Merge byte lanes 0 and 1 into the current register image.
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] dat,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] nxt;
    nxt = cur;
    if (strb[0]) begin
      nxt[7:0] = dat[7:0];
    end
    if (strb[1]) begin
      nxt[15:8] = dat[15:8];
    end
    merge = nxt & mask;
  endfunction : merge

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    wr_state_d = wr_state_q;
    bresp_d = bresp_q;
    wr_hit = 1'b1;
    prio_ctrl_can_spi_d = prio_ctrl_can_spi_q;
    prio_ctrl_capture_dma_d = prio_ctrl_capture_dma_q;
    prio_ctrl_twowire2_d = prio_ctrl_twowire2_q;
    prio_ctrl_ext_pins_d = prio_ctrl_ext_pins_q;
    prio_ctrl_encoder_pwm_d = prio_ctrl_encoder_pwm_q;
    prio_ctrl_serial_errors_d = prio_ctrl_serial_errors_q;
    prio_ctrl_can_transmit_d = prio_ctrl_can_transmit_q;
    if (aw_fire) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (w_fire) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    case (wr_state_q)
      irq_prio_pkg::WR_IDLE: begin
        if (wr_go) begin
          // Fields are laid out per register by the masks below.
          case (wr_addr)
            `PRIO_OFS_CAN_SPI: begin
              prio_ctrl_can_spi_d = merge(prio_ctrl_can_spi_q, wr_data, wr_strb,
                                          `PRIO_MASK_CAN_SPI);
            end
            `PRIO_OFS_CAPTURE_DMA: begin
              prio_ctrl_capture_dma_d = merge(prio_ctrl_capture_dma_q, wr_data, wr_strb,
                                              `PRIO_MASK_CAPTURE_DMA);
            end
            `PRIO_OFS_TWOWIRE2: begin
              prio_ctrl_twowire2_d = merge(prio_ctrl_twowire2_q, wr_data, wr_strb,
                                           `PRIO_MASK_MID_PAIR);
            end
            `PRIO_OFS_EXT_PINS: begin
              prio_ctrl_ext_pins_d = merge(prio_ctrl_ext_pins_q, wr_data, wr_strb,
                                           `PRIO_MASK_MID_PAIR);
            end
            `PRIO_OFS_ENCODER_PWM: begin
              prio_ctrl_encoder_pwm_d = merge(prio_ctrl_encoder_pwm_q, wr_data, wr_strb,
                                              `PRIO_MASK_MID_PAIR);
            end
            `PRIO_OFS_SERIAL_ERRORS: begin
              prio_ctrl_serial_errors_d = merge(prio_ctrl_serial_errors_q, wr_data, wr_strb,
                                                `PRIO_MASK_MID_PAIR);
            end
            `PRIO_OFS_CAN_TRANSMIT: begin
              prio_ctrl_can_transmit_d = merge(prio_ctrl_can_transmit_q, wr_data, wr_strb,
                                               `PRIO_MASK_CAN_TRANSMIT);
            end
            `PRIO_OFS_FEATURES: begin
              wr_hit = 1'b1;
            end
            default: begin
              wr_hit = 1'b0;
            end
          endcase
          bresp_d = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          aw_held_d = 1'b0;
          w_held_d = 1'b0;
          wr_state_d = irq_prio_pkg::WR_RESP;
        end
      end
      irq_prio_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_d = irq_prio_pkg::WR_IDLE;
        end
      end
      default: begin
        wr_state_d = irq_prio_pkg::WR_IDLE;
      end
    endcase
  end

  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_state_q)
      irq_prio_pkg::RD_IDLE: begin
        if (rd_go) begin
          rresp_d = `AXI_RESP_OKAY;
          case (s_axi_araddr)
            `PRIO_OFS_CAN_SPI: rdata_d = {16'h0000, prio_ctrl_can_spi_q};
            `PRIO_OFS_CAPTURE_DMA: rdata_d = {16'h0000, prio_ctrl_capture_dma_q};
            `PRIO_OFS_TWOWIRE2: rdata_d = {16'h0000, prio_ctrl_twowire2_q};
            `PRIO_OFS_EXT_PINS: rdata_d = {16'h0000, prio_ctrl_ext_pins_q};
            `PRIO_OFS_ENCODER_PWM: rdata_d = {16'h0000, prio_ctrl_encoder_pwm_q};
            `PRIO_OFS_SERIAL_ERRORS: rdata_d = {16'h0000, prio_ctrl_serial_errors_q};
            `PRIO_OFS_CAN_TRANSMIT: rdata_d = {16'h0000, prio_ctrl_can_transmit_q};
            `PRIO_OFS_FEATURES: rdata_d = {31'h0, can_present_q};
            default: begin
              rdata_d = 32'h00000000;
              rresp_d = `AXI_RESP_SLVERR;
            end
          endcase
          rd_state_d = irq_prio_pkg::RD_DATA;
        end
      end
      irq_prio_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_d = irq_prio_pkg::RD_IDLE;
        end
      end
      default: begin
        rd_state_d = irq_prio_pkg::RD_IDLE;
      end
    endcase
  end

  // The presence strap is sampled after reset so it never feeds the reset path.
  assign can_present_d = can_present;

  assign aw_ready_d = (wr_state_d == irq_prio_pkg::WR_IDLE) && !aw_held_d;
  assign w_ready_d = (wr_state_d == irq_prio_pkg::WR_IDLE) && !w_held_d;
  assign can_event_prio_d = can_present_d ? prio_ctrl_can_spi_d[14:12]
                            : `PRIO_LEVEL_OFF;
  assign can_rx_ready_prio_d = can_present_d ? prio_ctrl_can_spi_d[10:8]
                               : `PRIO_LEVEL_OFF;
  assign can_tx_request_prio_d = can_present_d ? prio_ctrl_can_transmit_d[10:8]
                                 : `PRIO_LEVEL_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_ctrl_can_spi_q <= `PRIO_RESET_CAN_SPI;
      prio_ctrl_capture_dma_q <= `PRIO_RESET_CAPTURE_DMA;
      prio_ctrl_twowire2_q <= `PRIO_RESET_MID_PAIR;
      prio_ctrl_ext_pins_q <= `PRIO_RESET_MID_PAIR;
      prio_ctrl_encoder_pwm_q <= `PRIO_RESET_MID_PAIR;
      prio_ctrl_serial_errors_q <= `PRIO_RESET_MID_PAIR;
      prio_ctrl_can_transmit_q <= `PRIO_RESET_CAN_TRANSMIT;
      can_present_q <= 1'b0;
      wr_state_q <= irq_prio_pkg::WR_IDLE;
      rd_state_q <= irq_prio_pkg::RD_IDLE;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= `AXI_RESP_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= `AXI_RESP_OKAY;
      aw_ready_q <= 1'b1;
      w_ready_q <= 1'b1;
      can_event_prio_q <= `PRIO_LEVEL_OFF;
      can_rx_ready_prio_q <= `PRIO_LEVEL_OFF;
      can_tx_request_prio_q <= `PRIO_LEVEL_OFF;
    end else begin
      prio_ctrl_can_spi_q <= prio_ctrl_can_spi_d;
      prio_ctrl_capture_dma_q <= prio_ctrl_capture_dma_d;
      prio_ctrl_twowire2_q <= prio_ctrl_twowire2_d;
      prio_ctrl_ext_pins_q <= prio_ctrl_ext_pins_d;
      prio_ctrl_encoder_pwm_q <= prio_ctrl_encoder_pwm_d;
      prio_ctrl_serial_errors_q <= prio_ctrl_serial_errors_d;
      prio_ctrl_can_transmit_q <= prio_ctrl_can_transmit_d;
      can_present_q <= can_present_d;
      wr_state_q <= wr_state_d;
      rd_state_q <= rd_state_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      aw_ready_q <= aw_ready_d;
      w_ready_q <= w_ready_d;
      can_event_prio_q <= can_event_prio_d;
      can_rx_ready_prio_q <= can_rx_ready_prio_d;
      can_tx_request_prio_q <= can_tx_request_prio_d;
    end
  end

  // Handshake outputs come straight from ready flops and one-hot state bits.
  assign s_axi_awready = aw_ready_q;
  assign s_axi_wready = w_ready_q;
  assign s_axi_bvalid = wr_state_q[1];
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = rd_state_q[0];
  assign s_axi_rvalid = rd_state_q[1];
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Level 0 is passed through as the disable code; levels 1 to 7 rank upward.
  assign can_event_prio = can_event_prio_q;
  assign can_rx_ready_prio = can_rx_ready_prio_q;
  assign serial_port_b_event_prio = prio_ctrl_can_spi_q[6:4];
  assign serial_port_b_error_prio = prio_ctrl_can_spi_q[2:0];
  assign capture_four_prio = prio_ctrl_capture_dma_q[10:8];
  assign capture_three_prio = prio_ctrl_capture_dma_q[6:4];
  assign xfer_chan_three_prio = prio_ctrl_capture_dma_q[2:0];
  assign twowire_b_master_prio = prio_ctrl_twowire2_q[10:8];
  assign twowire_b_slave_prio = prio_ctrl_twowire2_q[6:4];
  assign ext_pin_four_prio = prio_ctrl_ext_pins_q[10:8];
  assign ext_pin_three_prio = prio_ctrl_ext_pins_q[6:4];
  assign encoder_prio = prio_ctrl_encoder_pwm_q[10:8];
  assign pwm_special_match_prio = prio_ctrl_encoder_pwm_q[6:4];
  assign uart_b_error_prio = prio_ctrl_serial_errors_q[10:8];
  assign uart_a_error_prio = prio_ctrl_serial_errors_q[6:4];
  assign can_tx_request_prio = can_tx_request_prio_q;

  chk_reset_fields: assert property (@(posedge aclk) !aresetn |=>
    prio_ctrl_can_spi_q == `PRIO_RESET_CAN_SPI && uart_a_error_prio == `PRIO_FIELD_RESET)
    else $error("Priority fields did not reset to four.");

  chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (prio_ctrl_capture_dma_q & ~`PRIO_MASK_CAPTURE_DMA) == 16'h0000
    && (prio_ctrl_can_transmit_q & ~`PRIO_MASK_CAN_TRANSMIT) == 16'h0000)
    else $error("Unimplemented bits hold a one.");

  chk_can_absent_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !can_present_q |-> can_event_prio == 3'h0 && can_tx_request_prio == 3'h0)
    else $error("CAN source enabled without a CAN controller.");

  chk_write_next_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_addr == `PRIO_OFS_ENCODER_PWM && wr_strb[1] |=>
    encoder_prio == $past(wr_data[10:8]))
    else $error("Encoder priority write not seen next cycle.");

  chk_write_spi_error: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wr_addr == `PRIO_OFS_CAN_SPI && wr_strb[0] |=>
    serial_port_b_error_prio == $past(wr_data[2:0]))
    else $error("Serial port error priority write misplaced.");

  chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid && s_axi_bresp == ((($past(wr_addr) & 12'h003) == 12'h000
    && $past(wr_addr) <= `PRIO_OFS_FEATURES) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR))
    else $error("Write response missing or wrong.");

  chk_read_zero_top: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[15] == 1'b0)
    else $error("Read data has unimplemented bits set.");

  chk_read_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && s_axi_araddr == `PRIO_OFS_CAPTURE_DMA |=>
    s_axi_rdata[10:4] == {$past(capture_four_prio), 1'b0, $past(capture_three_prio)})
    else $error("Capture priority read back wrong.");

  sequence seq_can_spi_high;
    wr_go && wr_addr == `PRIO_OFS_CAN_SPI && wr_strb[1];
  endsequence

  chk_write_can_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_can_spi_high |=>
    prio_ctrl_can_spi_q[14:8] == {$past(wr_data[14:12]), 1'b0, $past(wr_data[10:8])})
    else $error("CAN priority fields written to the wrong bits.");

  sequence seq_capture_low;
    wr_go && wr_addr == `PRIO_OFS_CAPTURE_DMA && wr_strb[0];
  endsequence

  chk_write_xfer_chan: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_capture_low |=> xfer_chan_three_prio == $past(wr_data[2:0]))
    else $error("Transfer channel priority write misplaced.");

endmodule : irq_priority_regs_part
`default_nettype wire

/* File: verif/tb_irq_priority_regs_part.sv */
/*
  Self-checking bench for the interrupt priority register slice.
  Assumes one clock, a synchronous active-low reset and an AXI4-Lite slave.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_irq_priority_regs_part;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic can_present = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [2:0] p [16];
  logic [15:0] regs [7];
  int checked = 0;
  int bad_count = 0;
  int ri [16] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6};
  int lo [16] = '{12, 8, 4, 0, 8, 4, 0, 8, 4, 8, 4, 8, 4, 8, 4, 8};

  always #4 aclk = ~aclk;

  irq_priority_regs_part dut (
    .aclk(aclk), .aresetn(aresetn), .can_present(can_present),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .can_event_prio(p[0]), .can_rx_ready_prio(p[1]),
    .serial_port_b_event_prio(p[2]), .serial_port_b_error_prio(p[3]),
    .capture_four_prio(p[4]), .capture_three_prio(p[5]), .xfer_chan_three_prio(p[6]),
    .twowire_b_master_prio(p[7]), .twowire_b_slave_prio(p[8]),
    .ext_pin_four_prio(p[9]), .ext_pin_three_prio(p[10]),
    .encoder_prio(p[11]), .pwm_special_match_prio(p[12]),
    .uart_b_error_prio(p[13]), .uart_a_error_prio(p[14]), .can_tx_request_prio(p[15])
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_data(input string name, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask : cmp_data

  task automatic cmp_resp(input string name, input logic [1:0] e, input logic [1:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask : cmp_resp

  task automatic cmp_prio(input string name, input logic [2:0] e, input logic [2:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask : cmp_prio

  task automatic hang_check(input int n);
    if (n >= 50) begin
      bad_count++;
      $display("[ERR] handshake expected within 50 cycles seen none");
      wrap_up();
    end
  endtask : hang_check

  function automatic logic [15:0] mask_of(input logic [2:0] i);
    case (i)
      3'h0: return 16'h7777;
      3'h1: return 16'h0777;
      3'h6: return 16'h0700;
      default: return 16'h0770;
    endcase
  endfunction : mask_of

  // CAN source outputs are expected at level 0 when no CAN controller is present.
  task automatic chk_outs();
    logic [2:0] e;
    for (int k = 0; k < 16; k++) begin
      e = 3'((regs[ri[k]] >> lo[k]) & 16'h0007);
      if ((k == 0 || k == 1 || k == 15) && !can_present) e = 3'h0;
      cmp_prio($sformatf("prio %0d", k), e, p[k]);
    end
  endtask : chk_outs

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    logic [1:0] er;
    int n;
    m = 16'h0;
    er = (a <= 12'h01C) ? 2'h0 : 2'h2;
    if (a < 12'h01C) m = mask_of(a[4:2]) & {{8{s[1]}}, {8{s[0]}}};
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    hang_check(n);
    bready <= 1'b0;
    cmp_resp("bresp", er, bresp);
    if (a < 12'h01C) regs[a[4:2]] = (regs[a[4:2]] & ~m) | (d[15:0] & m);
    // Outputs must already carry the new value in the cycle the response shows.
    chk_outs();
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    logic [31:0] e;
    logic [1:0] er;
    int n;
    e = 32'h0;
    er = 2'h2;
    if (a < 12'h01C) begin
      e = {16'h0, regs[a[4:2]]};
      er = 2'h0;
    end else if (a == 12'h01C) begin
      e = {31'h0, can_present};
      er = 2'h0;
    end
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    hang_check(n);
    rready <= 1'b0;
    cmp_resp("rresp", er, rresp);
    cmp_data($sformatf("rdata %h", a), e, rdata);
  endtask : axi_read

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) regs[i] = mask_of(3'(i)) & 16'h4444;
    repeat (2) @(posedge aclk);
    chk_outs();
    for (int i = 0; i < 9; i++) axi_read(12'(i * 4));
  endtask : do_reset

  initial begin
    do_reset();
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) axi_write(12'(i * 4), 32'hFFFF_FFFF, 4'hF);
    for (int i = 0; i < 8; i++) axi_read(12'(i * 4));
    $display("test all_ones done");
    for (int v = 0; v < 8; v++) begin
      for (int i = 0; i < 7; i++) axi_write(12'(i * 4), {16'h0, {4{1'b0, 3'(v)}}}, 4'h3);
      axi_read(12'(v * 4 % 28));
    end
    $display("test level_sweep done");
    axi_write(12'h000, 32'hFFFF_0000, 4'hC);
    axi_write(12'h000, 32'h0000_5A5A, 4'h1);
    axi_write(12'h004, 32'h0000_3636, 4'h2);
    axi_read(12'h000);
    axi_read(12'h004);
    $display("test byte_strobes done");
    // A CAN-less variant keeps the stored fields; only the outputs are forced off.
    can_present <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_outs();
    axi_write(12'h000, 32'h0000_6363, 4'h3);
    axi_write(12'h018, 32'h0000_0500, 4'h3);
    axi_read(12'h000);
    axi_read(12'h018);
    axi_read(12'h01C);
    can_present <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_outs();
    $display("test can_absent done");
    axi_write(12'h020, 32'h0000_0000, 4'hF);
    axi_read(12'h020);
    axi_read(12'hFFC);
    $display("test unmapped done");
    do_reset();
    $display("test second_reset done");
    wrap_up();
  end
endmodule : tb_irq_priority_regs_part
`default_nettype wire
